// >>> rtl/lcp_pkg.sv
// Constants and types shared by the LED pair current serial control block.
// Assumes a single 50 MHz clock and a synchronous active-low reset.
package lcp_pkg;
	// Own bus address and register indexes.
	localparam logic [6:0] OWN_ADDR = 7'h66;
	localparam logic [1:0] IDX_PAIR_ONE = 2'h0;
	localparam logic [1:0] IDX_PAIR_TWO = 2'h1;
	localparam logic [1:0] IDX_PAIR_THREE = 2'h2;
	localparam logic [1:0] IDX_CHAN_MASK = 2'h3;
	localparam logic [7:0] IDX_LAST = 8'h03;
	localparam int REG_COUNT = 4;
	// Field layout and reset values.
	localparam int CHAN_COUNT = 6;
	localparam int PAIR_COUNT = 3;
	localparam logic [7:0] CHAN_MASK_BITS = 8'h3F;
	localparam logic [7:0] CURRENT_RESET = 8'h00;
	localparam logic [7:0] CHAN_MASK_RESET = 8'h3F;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	// Code 0x40 is 32 mA at 0.5 mA per step; larger codes saturate.
	localparam logic [7:0] CURRENT_CODE_MAX = 8'h40;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// Bus timing: sampling margin at the fastest allowed bit rate.
	localparam int CLOCK_PERIOD_NS = 20;
	localparam int BUS_BIT_PERIOD_NS = 2500;
	localparam int BUS_BIT_CYCLES = BUS_BIT_PERIOD_NS / CLOCK_PERIOD_NS;
	// Bus protocol states.
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_INDEX, ST_ACK_INDEX,
		ST_WDATA, ST_ACK_WDATA, ST_RDATA, ST_RACK, ST_IGNORE
	} lcp_state_type;
endpackage

// >>> rtl/lcp_reg_bank.sv
// Small register store for the LED pair current block: four 8-bit words.
// Assumes writes and the shutdown clear come from logic on the same clock.
`timescale 1ns/1ps
module lcp_reg_bank
	import lcp_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic clear_i,
	input wire logic wr_en_i,
	input wire logic [1:0] wr_idx_i,
	input wire logic [7:0] wr_data_i,
	input wire logic [1:0] rd_idx_i,
	output logic [7:0] rd_data_o,
	output logic [8*REG_COUNT-1:0] words_o
);
	logic [7:0] mem_reg [REG_COUNT];
	logic [7:0] mem_next [REG_COUNT];
	logic [7:0] rd_data_reg;
	logic [7:0] rd_data_next;

	// Each word reloads its reset value on clear, so shutdown forgets settings.
	generate
		for (genvar w = 0; w < REG_COUNT; w++) begin : g_word
			localparam logic [7:0] RST_VAL = (w == int'(IDX_CHAN_MASK)) ?
				CHAN_MASK_RESET : CURRENT_RESET;
			always_comb begin
				mem_next[w] = mem_reg[w];
				if (clear_i) begin
					mem_next[w] = RST_VAL;
				end else if (wr_en_i && (wr_idx_i == 2'(w))) begin
					mem_next[w] = wr_data_i;
				end
			end
			always_ff @(posedge clock_i) begin
				if (!rst_n_i) begin
					mem_reg[w] <= RST_VAL;
				end else begin
					mem_reg[w] <= mem_next[w];
				end
			end
			assign words_o[8*w +: 8] = mem_reg[w];
		end
	endgenerate

	// Read data always come out of a register, one cycle after the index.
	always_comb begin
		rd_data_next = mem_reg[rd_idx_i];
	end
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			rd_data_reg <= CURRENT_RESET;
		end else begin
			rd_data_reg <= rd_data_next;
		end
	end
	assign rd_data_o = rd_data_reg;
endmodule

// >>> rtl/lcp_serial_ctrl.sv
// Two-wire serial target for a six-channel LED current driver.
// Assumes scl_i, sda_i and enable_i are asynchronous pins, the bus wire is
// open drain with an external pull-up, and the clock is 50 MHz.
// Behaviour
// (R01) Six channels form three pairs sharing current.
// (R02) Pair current 0 to 32 mA, 0.5 mA steps.
// (R03) Each channel can be switched off alone.
// (R04) Enable low forces shutdown, all outputs off.
// (R05) Answer only to address 1100110.
// (R06) Work at bus rates up to 400 kbit/s.
// (R07) Master starts all transfers; device only acknowledges. The code also drives the read data bits.
// (R08) Write: address, index, data, each acknowledged.
// (R09) Read: index write, repeated start, one byte.
// (R10) Lines released high when bus idle.
// (R11) Three separate 8-bit pair current registers.
// (R12) Host may dim by toggling the mask.
// (R13) Foreign address: no acknowledge, ignore until start.
`timescale 1ns/1ps
module lcp_serial_ctrl
	import lcp_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic enable_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic [7:0] pair_one_current_o,
	output logic [7:0] pair_two_current_o,
	output logic [7:0] pair_three_current_o,
	output logic [CHAN_COUNT-1:0] led_on_o
);
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic [1:0] en_sync_reg;
	logic scl_prev_reg;
	logic sda_prev_reg;
	logic scl_s;
	logic sda_s;
	logic en_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	// Two flip-flops per pin; at 50 MHz a 400 kbit/s bit lasts BUS_BIT_CYCLES.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			en_sync_reg <= 2'h0;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_i}; // R06
			sda_sync_reg <= {sda_sync_reg[0], sda_i};
			en_sync_reg <= {en_sync_reg[0], enable_i};
			scl_prev_reg <= scl_sync_reg[1];
			sda_prev_reg <= sda_sync_reg[1];
		end
	end
	assign scl_s = scl_sync_reg[1];
	assign sda_s = sda_sync_reg[1];
	assign en_s = en_sync_reg[1];

	// Bus events; start and stop are data edges while the clock is high.
	assign scl_rise = scl_s && !scl_prev_reg;
	assign scl_fall = !scl_s && scl_prev_reg;
	assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s; // R07
	assign stop_det = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

	lcp_state_type state_reg, state_next;
	logic [7:0] shift_reg, shift_next;
	logic [7:0] tx_reg, tx_next;
	logic [3:0] bit_cnt_reg, bit_cnt_next;
	logic [7:0] index_reg, index_next;
	logic drive_low_reg, drive_low_next;
	logic wr_en;
	logic [7:0] wr_data;
	logic [7:0] rd_word;
	logic [8*REG_COUNT-1:0] words;
	logic index_mapped;

	assign index_mapped = (index_reg <= IDX_LAST);

	// Protocol sequencer: bits are taken on clock rise and driven on clock fall.
	always_comb begin
		state_next = state_reg;
		shift_next = shift_reg;
		tx_next = tx_reg;
		bit_cnt_next = bit_cnt_reg;
		index_next = index_reg;
		drive_low_next = drive_low_reg;
		wr_en = 1'b0;
		wr_data = shift_reg;
		if (!en_s) begin
			state_next = ST_IDLE; // R04
			drive_low_next = 1'b0;
		end else if (start_det) begin
			state_next = ST_ADDR; // R07
			bit_cnt_next = 4'h0;
			drive_low_next = 1'b0;
		end else if (stop_det) begin
			state_next = ST_IDLE; // R10
			drive_low_next = 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE, ST_IGNORE: begin
					drive_low_next = 1'b0; // R13
				end
				ST_ADDR, ST_INDEX, ST_WDATA: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda_s};
						bit_cnt_next = bit_cnt_reg + 4'h1;
					end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
						bit_cnt_next = 4'h0;
						if (state_reg == ST_ADDR) begin
							if (shift_reg[7:1] == OWN_ADDR) begin
								state_next = ST_ACK_ADDR; // R05
								drive_low_next = 1'b1;
							end else begin
								state_next = ST_IGNORE; // R13
							end
						end else if (state_reg == ST_INDEX) begin
							index_next = shift_reg;
							state_next = ST_ACK_INDEX; // R08
							drive_low_next = 1'b1;
						end else begin
							wr_en = index_mapped;
							if (index_reg[1:0] == IDX_CHAN_MASK) begin
								wr_data = shift_reg & CHAN_MASK_BITS; // R03
							end
							state_next = ST_ACK_WDATA; // R08
							drive_low_next = 1'b1;
						end
					end
				end
				ST_ACK_ADDR: begin
					if (scl_fall) begin
						if (shift_reg[0]) begin
							// Read: first data bit goes out on this same fall.
							tx_next = index_mapped ? rd_word : UNMAPPED_READ; // R09
							drive_low_next = !tx_next[7];
							state_next = ST_RDATA;
						end else begin
							drive_low_next = 1'b0;
							state_next = ST_INDEX;
						end
					end
				end
				ST_ACK_INDEX, ST_ACK_WDATA: begin
					if (scl_fall) begin
						drive_low_next = 1'b0;
						// Extra data bytes rewrite the same index.
						state_next = ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (scl_rise) begin
						bit_cnt_next = bit_cnt_reg + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt_reg == BITS_PER_BYTE) begin
							bit_cnt_next = 4'h0;
							drive_low_next = 1'b0;
							state_next = ST_RACK;
						end else begin
							tx_next = {tx_reg[6:0], 1'b1};
							drive_low_next = !tx_next[7]; // R09
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						// A not-acknowledge ends the read; an acknowledge repeats it.
						state_next = sda_s ? ST_IGNORE : ST_ACK_ADDR; // R09
					end
				end
				default: begin
					state_next = ST_IDLE;
					drive_low_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_IDLE;
			shift_reg <= 8'h00;
			tx_reg <= 8'hFF;
			bit_cnt_reg <= 4'h0;
			index_reg <= 8'h00;
			drive_low_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			tx_reg <= tx_next;
			bit_cnt_reg <= bit_cnt_next;
			index_reg <= index_next;
			drive_low_reg <= drive_low_next;
		end
	end

	// Open drain: the wire is only ever pulled low, never driven high.
	assign sda_o = 1'b0;
	assign sda_oe_o = drive_low_reg; // R10

	lcp_reg_bank u_bank (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.clear_i(!en_s),
		.wr_en_i(wr_en),
		.wr_idx_i(index_reg[1:0]),
		.wr_data_i(wr_data),
		.rd_idx_i(index_reg[1:0]),
		.rd_data_o(rd_word),
		.words_o(words)
	);

	logic [7:0] cur_next [PAIR_COUNT];
	logic [7:0] cur_reg [PAIR_COUNT];
	logic [CHAN_COUNT-1:0] led_next, led_reg;

	// Codes above full scale saturate, so no pair is ever set past 32 mA.
	generate
		for (genvar p = 0; p < PAIR_COUNT; p++) begin : g_pair
			always_comb begin
				cur_next[p] = CURRENT_RESET;
				if (en_s) begin
					cur_next[p] = (words[8*p +: 8] > CURRENT_CODE_MAX) ?
						CURRENT_CODE_MAX : words[8*p +: 8]; // R02 R11
				end
			end
			always_ff @(posedge clock_i) begin
				if (!rst_n_i) begin
					cur_reg[p] <= CURRENT_RESET;
				end else begin
					cur_reg[p] <= cur_next[p];
				end
			end
		end
	endgenerate

	// Channels 2p and 2p+1 both follow pair p; the mask gates each one.
	always_comb begin
		led_next = en_s ? words[8*int'(IDX_CHAN_MASK) +: CHAN_COUNT] : '0; // R01 R03 R04
	end
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			led_reg <= '0;
		end else begin
			led_reg <= led_next;
		end
	end
	assign pair_one_current_o = cur_reg[IDX_PAIR_ONE];
	assign pair_two_current_o = cur_reg[IDX_PAIR_TWO];
	assign pair_three_current_o = cur_reg[IDX_PAIR_THREE];
	assign led_on_o = led_reg;

	// Checks on the sequencer and outputs.
	chk_shutdown_dark: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R04
		!en_s |=> (led_on_o == '0) && (pair_one_current_o == CURRENT_RESET) && !sda_oe_o)
		else $error("outputs active during shutdown");
	chk_current_limit: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R02
		pair_one_current_o <= CURRENT_CODE_MAX && pair_two_current_o <= CURRENT_CODE_MAX
		&& pair_three_current_o <= CURRENT_CODE_MAX)
		else $error("pair current above full scale");
	chk_ack_own_addr: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R05
		(state_reg == ST_ADDR) && ($past(state_reg) == ST_ADDR) ##1 (state_reg == ST_ACK_ADDR)
		|-> shift_reg[7:1] == OWN_ADDR)
		else $error("acknowledged a foreign address");
	chk_foreign_quiet: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R13
		(state_reg == ST_IGNORE) && !start_det |=> !sda_oe_o && (state_reg != ST_ACK_ADDR))
		else $error("ignored transfer drove the bus");
	chk_idle_release: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R10
		(state_reg == ST_IDLE) [*2] |-> !sda_oe_o)
		else $error("data line held while idle");
	chk_start_resets: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R07
		start_det && en_s |=> (state_reg == ST_ADDR) && (bit_cnt_reg == 4'h0))
		else $error("start did not restart address phase");
	chk_write_lands: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R11
		wr_en && en_s && (index_reg[1:0] == IDX_PAIR_TWO) && (wr_data <= CURRENT_CODE_MAX)
		##1 en_s [*2] |-> pair_two_current_o == $past(wr_data, 2))
		else $error("pair current write not seen at output");
	chk_read_bit: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R09
		(state_reg == ST_RDATA) && $stable(state_reg) |-> sda_oe_o == !tx_reg[7])
		else $error("read bit driven wrongly");
	chk_chan_off: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R03
		en_s |=> led_on_o == $past(words[8*int'(IDX_CHAN_MASK) +: CHAN_COUNT]))
		else $error("channel mask not applied");
	chk_unmapped_read: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R09
		(state_reg == ST_ACK_ADDR) ##1 (state_reg == ST_RDATA) && !index_mapped
		|-> tx_reg == UNMAPPED_READ)
		else $error("unmapped register read not zero");
	// Covers for the main scenarios; shutdown and saturation are easy to skip by accident.
	cov_write: cover property (@(posedge clock_i) disable iff (!rst_n_i)
		state_reg == ST_ACK_WDATA);
	cov_read_nack: cover property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_reg == ST_RACK) ##1 (state_reg == ST_IGNORE));
	cov_foreign: cover property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_reg == ST_ADDR) ##1 (state_reg == ST_IGNORE));
	cov_shutdown: cover property (@(posedge clock_i) disable iff (!rst_n_i)
		$fell(en_s));
	cov_saturate: cover property (@(posedge clock_i) disable iff (!rst_n_i)
		words[8*int'(IDX_PAIR_ONE) +: 8] > CURRENT_CODE_MAX);
endmodule

// >>> bench/lcp_bus_master.sv
// Behavioural bus master for the LED pair current serial block.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
module lcp_bus_master
	import lcp_pkg::*;
(
	input wire logic clock_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_pull_o
);
	// Quarter bit of 32 cycles: 128 cycles a bit, just under the top rate.
	localparam int QUARTER = 32;
	// Both lines start released, so the bus rests high.
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	// Every change lands just after a clock edge.
	task automatic q();
		repeat (QUARTER) @(posedge clock_i);
		#1;
	endtask
	// Start or repeated start: data falls while the clock is high.
	task automatic start();
		sda_pull_o = 1'b0;
		q();
		scl_o = 1'b1;
		q();
		sda_pull_o = 1'b1;
		q();
		scl_o = 1'b0;
		q();
	endtask
	// Stop releases both lines.
	task automatic stop();
		sda_pull_o = 1'b1;
		q();
		scl_o = 1'b1;
		q();
		sda_pull_o = 1'b0;
		q();
	endtask
	// One bit; data changes only while the clock is low.
	task automatic clk_bit(input logic pull, output logic b);
		sda_pull_o = pull;
		q();
		scl_o = 1'b1;
		q();
		b = sda_i;
		q();
		scl_o = 1'b0;
		q();
	endtask
	// Bytes go out most significant bit first; ninth bit is the answer.
	task automatic send(input logic [7:0] v, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(!v[i], b);
		end
		clk_bit(1'b0, b);
		ack = !b;
	endtask
	task automatic recv(output logic [7:0] v);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b0, v[i]);
		end
		clk_bit(1'b0, b);
	endtask
	// Address is an argument so the bench can aim at a foreign target.
	task automatic write_reg(input logic [6:0] ad, input logic [7:0] idx,
		input logic [7:0] d, output logic [2:0] a);
		start();
		send({ad, 1'b0}, a[2]);
		send(idx, a[1]);
		send(d, a[0]);
		stop();
	endtask
	task automatic read_reg(input logic [7:0] idx, output logic [7:0] v,
		output logic [2:0] a);
		start();
		send({OWN_ADDR, 1'b0}, a[2]);
		send(idx, a[1]);
		start();
		send({OWN_ADDR, 1'b1}, a[0]);
		recv(v);
		stop();
	endtask
endmodule

// >>> bench/tb_lcp_serial_ctrl.sv
// Self-checking bench for the LED pair current serial block.
// Assumes the bus master model and a 50 MHz clock.
`timescale 1ns/1ps
module tb_lcp_serial_ctrl;
	import lcp_pkg::*;
	logic clock_i, rst_n_i, enable_i, scl, sda_m, sda_o, sda_oe_o;
	logic [7:0] p1, p2, p3;
	logic [5:0] led;
	wire logic sda_w;
	int err_total, tests_run;
	// Any party pulling wins; otherwise the pull-up holds the wire high.
	assign sda_w = !(sda_oe_o || sda_m);
	lcp_serial_ctrl dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.enable_i(enable_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .pair_one_current_o(p1), .pair_two_current_o(p2),
		.pair_three_current_o(p3), .led_on_o(led));
	lcp_bus_master mst_u (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl),
		.sda_pull_o(sda_m));
	// Free-running clock.
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = !clock_i;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [2:0] a;
		mst_u.write_reg(OWN_ADDR, idx, d, a);
		chk({5'h00, a}, 8'h07);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		logic [2:0] a;
		logic [7:0] v;
		mst_u.read_reg(idx, v, a);
		chk({5'h00, a}, 8'h07);
		chk(v, exp);
	endtask
	task automatic t_pairs();
		wr(8'h00, 8'h40);
		wr(8'h01, 8'h01);
		wr(8'h02, 8'h2A);
		chk(p1, 8'h40);
		chk(p2, 8'h01);
		chk(p3, 8'h2A);
		// A code past full scale is kept but drives no more than full scale.
		wr(8'h00, 8'h41);
		chk(p1, 8'h40);
		rd(8'h00, 8'h41);
		$display("test pairs done");
	endtask
	task automatic t_mask();
		wr(8'h03, 8'h3B);
		chk({2'h0, led}, 8'h3B);
		chk(p2, 8'h01);
		wr(8'h03, 8'h00);
		chk({2'h0, led}, 8'h00);
		wr(8'h03, 8'h3F);
		chk({2'h0, led}, 8'h3F);
		$display("test mask done");
	endtask
	task automatic t_foreign();
		logic [2:0] a;
		mst_u.write_reg(7'h67, 8'h01, 8'h77, a);
		chk({5'h00, a}, 8'h00);
		chk(p2, 8'h01);
		wr(8'h01, 8'h05);
		chk(p2, 8'h05);
		$display("test foreign done");
	endtask
	task automatic t_index();
		wr(8'h05, 8'h55);
		rd(8'h05, 8'h00);
		// Index 5 aliases pair two in its low bits, so pair two must stay put.
		chk(p2, 8'h05);
		chk(p3, 8'h2A);
		chk({6'h00, sda_oe_o, !scl}, 8'h00);
		chk({7'h00, sda_o}, 8'h00);
		$display("test index done");
	endtask
	task automatic t_shutdown();
		logic [2:0] a;
		@(posedge clock_i);
		#1;
		enable_i = 1'b0;
		repeat (8) @(posedge clock_i);
		chk({2'h0, led}, 8'h00);
		chk(p2, 8'h00);
		mst_u.write_reg(OWN_ADDR, 8'h01, 8'h11, a);
		chk({5'h00, a}, 8'h00);
		@(posedge clock_i);
		#1;
		enable_i = 1'b1;
		repeat (8) @(posedge clock_i);
		chk({2'h0, led}, 8'h3F);
		chk(p2, 8'h00);
		$display("test shutdown done");
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Main sequence: reset for 8 cycles, then the scenarios in order.
	initial begin
		err_total = 0;
		tests_run = 0;
		rst_n_i = 1'b0;
		enable_i = 1'b1;
		repeat (8) @(posedge clock_i);
		#1;
		rst_n_i = 1'b1;
		repeat (8) @(posedge clock_i);
		#1;
		chk(p1, 8'h00);
		chk({2'h0, led}, 8'h3F);
		t_pairs();
		t_mask();
		t_foreign();
		t_index();
		t_shutdown();
		results();
	end
	// The scenarios take about 50000 cycles; a hang is cut off well after.
	initial begin
		repeat (75000) @(posedge clock_i);
		err_total++;
		results();
	end
endmodule
